// File: pmsc_core_ctrl.sv
// Base priority mask, thread stack/privilege control and memory ordering
//
// Operation
// - Nonzero mask refuses exceptions with priority value at or above it.
// - Mask sits in bits 7:4; zero disables masking.
// - Higher priority value means lower urgency in every comparison.
// - Control bit 2 flags live float context, deciding float save on entry.
// - Control bit 1 picks main stack when 0, process stack when 1.
// - Handler mode reads stack select as zero and ignores writes to it.
// - Exception entry and return update control; return restores stack select.
// - Control bit 0: 0 privileged thread, 1 unprivileged thread.
// - After reset thread uses main stack; write or return code switches it.
// - Every handler except reset runs in Handler mode.
// - Word, halfword and byte accesses, all little-endian.
// - Normal regions may be reordered and read speculatively.
// - Device accesses stay ordered against Device and strongly-ordered ones.
// - Strongly-ordered accesses stay ordered against every access.
// - Device writes may be posted; strongly-ordered writes never.
// - Fetch from execute-never region is blocked and raises a fault.
// - Fixed memory map spanning a 4 GB address space.
`timescale 1ns/10ps
module pmsc_core_ctrl #(
  parameter int CNT_W = 4
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // Special register move port
  input wire logic i_sreg_wr,
  input wire logic i_sreg_rd,
  input wire logic i_sreg_sel,
  input wire logic [31:0] i_sreg_wdata,
  output logic [31:0] o_sreg_rdata,
  // Exception sequencing
  input wire logic i_exc_entry,
  input wire logic i_exception_return_code,
  input wire logic [pmsc_pkg::RET_CODE_W-1:0] i_exception_return_code_code,
  input wire logic [7:0] i_exc_req_prio,
  output logic o_exc_req_allow,
  output logic o_handler_mode,
  output logic o_stack_select,
  output logic o_thread_unprivileged,
  output logic o_save_float_state,
  // Core access request
  input wire logic i_txn_valid,
  input wire logic i_txn_fetch,
  input wire logic i_txn_write,
  input wire logic [1:0] i_txn_size,
  input wire logic [31:0] i_txn_addr,
  input wire logic [31:0] i_txn_wdata,
  output logic o_txn_ready,
  output logic o_wr_posted,
  output logic o_txn_complete,
  output logic o_mm_fault,
  output logic [31:0] o_fault_addr,
  // Memory bus side
  output logic o_bus_valid,
  output logic [31:0] o_bus_addr,
  output logic o_bus_write,
  output logic [3:0] o_bus_strb,
  output logic [31:0] o_bus_wdata,
  output pmsc_pkg::pmsc_mem_t o_bus_kind,
  input wire logic i_bus_ready,
  input wire logic i_bus_done,
  input wire logic i_bus_done_write,
  input wire pmsc_pkg::pmsc_mem_t i_bus_done_kind
);

  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_FULL = '1;

  logic [3:0] base_pri_r;
  logic stack_pointer_select_r;
  logic unpriv_r;
  logic float_context_active_r;
  pmsc_pkg::pmsc_mode_t mode_r;
  logic handler;
  logic ctrl_wr;
  logic base_wr;
  pmsc_pkg::pmsc_mem_t in_kind;
  logic in_xn;
  logic xn_fetch;
  logic gate_ok;
  logic take;
  logic issue;
  logic accept;
  logic done_ord;
  logic done_strong;
  logic [CNT_W-1:0] any_cnt_r;
  logic [CNT_W-1:0] ord_cnt_r;
  logic [CNT_W-1:0] so_cnt_r;
  logic [3:0] strb_nxt;
  logic [31:0] lane_nxt;

  assign handler = (mode_r == pmsc_pkg::MODE_HANDLER);
  assign ctrl_wr = i_sreg_wr && (i_sreg_sel == pmsc_pkg::SREG_SEL_CONTROL);
  assign base_wr = i_sreg_wr && (i_sreg_sel == pmsc_pkg::SREG_SEL_BASE_PRI);

  // ****************************************************************
  // Base priority mask
  // ****************************************************************
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      base_pri_r <= pmsc_pkg::BASE_PRI_RST;
    end else if (base_wr) begin
      base_pri_r <= i_sreg_wdata[pmsc_pkg::BASE_PRI_MSB:pmsc_pkg::BASE_PRI_LSB];
    end
  end

  // Larger value is less urgent, so it is the one that gets held off
  always_comb begin
    if (base_pri_r == pmsc_pkg::BASE_PRI_OFF) begin
      o_exc_req_allow = 1'b1;
    end else begin
      o_exc_req_allow = (i_exc_req_prio < {base_pri_r, pmsc_pkg::PRIO_SUB_ZERO});
    end
  end

  // ****************************************************************
  // Processor mode
  // ****************************************************************
  // Reset is taken in Thread mode, every other exception enters Handler
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mode_r <= pmsc_pkg::MODE_THREAD;
    end else begin
      unique case (mode_r)
        pmsc_pkg::MODE_THREAD: begin
          if (i_exc_entry) begin
            mode_r <= pmsc_pkg::MODE_HANDLER;
          end
        end
        pmsc_pkg::MODE_HANDLER: begin
          if (i_exc_entry) begin
            mode_r <= pmsc_pkg::MODE_HANDLER;
          end else if (i_exception_return_code && i_exception_return_code_code[pmsc_pkg::RET_TO_THREAD_BIT]) begin
            mode_r <= pmsc_pkg::MODE_THREAD;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Control register
  // ****************************************************************
  // Hardware sequencing beats a software write in the same cycle
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stack_pointer_select_r <= pmsc_pkg::CTRL_STACK_POINTER_SELECT_RST;
    end else if (i_exception_return_code && handler && i_exception_return_code_code[pmsc_pkg::RET_TO_THREAD_BIT]) begin
      stack_pointer_select_r <= i_exception_return_code_code[pmsc_pkg::RET_PROC_STACK_BIT];
    end else if (ctrl_wr && !handler && !i_exc_entry) begin
      stack_pointer_select_r <= i_sreg_wdata[pmsc_pkg::CTRL_STACK_POINTER_SELECT_BIT];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      unpriv_r <= pmsc_pkg::CTRL_UNPRIV_RST;
    end else if (ctrl_wr) begin
      unpriv_r <= i_sreg_wdata[pmsc_pkg::CTRL_UNPRIV_BIT];
    end
  end

  // Entry stacks the float state, so the handler starts with none live
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      float_context_active_r <= pmsc_pkg::CTRL_FLOAT_CONTEXT_ACTIVE_RST;
    end else if (i_exc_entry) begin
      float_context_active_r <= 1'b0;
    end else if (i_exception_return_code && handler) begin
      float_context_active_r <= !i_exception_return_code_code[pmsc_pkg::RET_NO_FLOAT_BIT];
    end else if (ctrl_wr) begin
      float_context_active_r <= i_sreg_wdata[pmsc_pkg::CTRL_FLOAT_CONTEXT_ACTIVE_BIT];
    end
  end

  assign o_handler_mode = handler;
  assign o_stack_select = stack_pointer_select_r && !handler;
  assign o_thread_unprivileged = unpriv_r;
  assign o_save_float_state = float_context_active_r;

  // ****************************************************************
  // Special register read
  // ****************************************************************
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sreg_rdata <= 32'h0000_0000;
    end else if (i_sreg_rd) begin
      o_sreg_rdata <= 32'h0000_0000;
      if (i_sreg_sel == pmsc_pkg::SREG_SEL_BASE_PRI) begin
        o_sreg_rdata[pmsc_pkg::BASE_PRI_MSB:pmsc_pkg::BASE_PRI_LSB] <= base_pri_r;
      end else begin
        o_sreg_rdata[pmsc_pkg::CTRL_UNPRIV_BIT] <= unpriv_r;
        o_sreg_rdata[pmsc_pkg::CTRL_STACK_POINTER_SELECT_BIT] <= stack_pointer_select_r && !handler;
        o_sreg_rdata[pmsc_pkg::CTRL_FLOAT_CONTEXT_ACTIVE_BIT] <= float_context_active_r;
      end
    end
  end

  // ****************************************************************
  // Region decode and issue gating
  // ****************************************************************
  pmsc_region_map pmsc_region_map_inst (
    .i_addr(i_txn_addr),
    .o_mem_type(in_kind),
    .o_execute_never(in_xn)
  );

  // Normal only waits behind strongly-ordered; reorder freedom is not used
  always_comb begin
    gate_ok = (any_cnt_r != CNT_FULL);
    unique case (in_kind)
      pmsc_pkg::MEM_NORMAL: gate_ok = gate_ok && (so_cnt_r == CNT_ZERO);
      pmsc_pkg::MEM_DEVICE: gate_ok = gate_ok && (ord_cnt_r == CNT_ZERO);
      pmsc_pkg::MEM_STRONG: gate_ok = gate_ok && (any_cnt_r == CNT_ZERO);
      default: gate_ok = 1'b0;
    endcase
  end

  assign xn_fetch = i_txn_fetch && in_xn;
  assign o_txn_ready = !o_bus_valid && (xn_fetch || gate_ok);
  assign take = i_txn_valid && o_txn_ready;
  assign issue = take && !xn_fetch;
  assign accept = o_bus_valid && i_bus_ready;
  assign done_ord = i_bus_done && (i_bus_done_kind != pmsc_pkg::MEM_NORMAL);
  assign done_strong = i_bus_done && (i_bus_done_kind == pmsc_pkg::MEM_STRONG);

  // ****************************************************************
  // Outstanding access counters
  // ****************************************************************
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      any_cnt_r <= CNT_ZERO;
      ord_cnt_r <= CNT_ZERO;
      so_cnt_r <= CNT_ZERO;
    end else begin
      any_cnt_r <= any_cnt_r + CNT_W'(issue) - CNT_W'(i_bus_done);
      ord_cnt_r <= ord_cnt_r + CNT_W'(issue && in_kind != pmsc_pkg::MEM_NORMAL) - CNT_W'(done_ord);
      so_cnt_r <= so_cnt_r + CNT_W'(issue && in_kind == pmsc_pkg::MEM_STRONG) - CNT_W'(done_strong);
    end
  end

  // ****************************************************************
  // Little-endian lane placement
  // ****************************************************************
  always_comb begin
    unique case (i_txn_size)
      pmsc_pkg::SIZE_BYTE: begin
        strb_nxt = 4'h1 << i_txn_addr[1:0];
        lane_nxt = {4{i_txn_wdata[7:0]}};
      end
      pmsc_pkg::SIZE_HALF: begin
        strb_nxt = i_txn_addr[1] ? 4'hC : 4'h3;
        lane_nxt = {2{i_txn_wdata[15:0]}};
      end
      default: begin
        strb_nxt = 4'hF;
        lane_nxt = i_txn_wdata;
      end
    endcase
  end

  // ****************************************************************
  // Bus request register
  // ****************************************************************
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_bus_valid <= 1'b0;
    end else if (issue) begin
      o_bus_valid <= 1'b1;
    end else if (accept) begin
      o_bus_valid <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_bus_addr <= 32'h0000_0000;
      o_bus_write <= 1'b0;
      o_bus_strb <= 4'h0;
      o_bus_wdata <= 32'h0000_0000;
      o_bus_kind <= pmsc_pkg::MEM_NORMAL;
    end else if (issue) begin
      o_bus_addr <= i_txn_addr;
      o_bus_write <= i_txn_write;
      o_bus_strb <= strb_nxt;
      o_bus_wdata <= lane_nxt;
      o_bus_kind <= in_kind;
    end
  end

  // ****************************************************************
  // Completion, posting and fault reporting
  // ****************************************************************
  // A posted write is acknowledged at acceptance; its later done is silent
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_wr_posted <= 1'b0;
      o_txn_complete <= 1'b0;
    end else begin
      o_wr_posted <= accept && o_bus_write && (o_bus_kind != pmsc_pkg::MEM_STRONG);
      o_txn_complete <= i_bus_done && !(i_bus_done_write && i_bus_done_kind != pmsc_pkg::MEM_STRONG);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_mm_fault <= 1'b0;
      o_fault_addr <= 32'h0000_0000;
    end else begin
      o_mm_fault <= take && xn_fetch;
      if (take && xn_fetch) begin
        o_fault_addr <= i_txn_addr;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_xn_fetch;
    i_txn_valid && o_txn_ready && i_txn_fetch && in_xn;
  endsequence

  sequence s_fault_raised;
    o_mm_fault && !o_bus_valid;
  endsequence

  a_mask_blocks_low: assert property ((base_pri_r != 4'h0) && (i_exc_req_prio[7:4] >= base_pri_r)
    |-> !o_exc_req_allow) else $error("masked priority allowed");
  a_mask_off_open: assert property ((base_pri_r == 4'h0) |-> o_exc_req_allow)
    else $error("zero mask blocked a request");
  a_urgent_passes: assert property ((i_exc_req_prio[7:4] < base_pri_r) |-> o_exc_req_allow)
    else $error("more urgent request blocked");
  a_handler_reads_msp: assert property (handler |-> !o_stack_select)
    else $error("stack select visible in handler");
  a_handler_write_ignored: assert property (handler && ctrl_wr && !i_exception_return_code |=> $stable(stack_pointer_select_r))
    else $error("stack select written in handler");
  a_entry_updates_ctrl: assert property (i_exc_entry |=> handler && !float_context_active_r)
    else $error("entry did not update control");
  a_return_restores_sp: assert property (handler && i_exception_return_code && i_exception_return_code_code[3]
    |=> !handler && (stack_pointer_select_r == $past(i_exception_return_code_code[2]))) else $error("return did not restore stack");
  a_strong_alone: assert property (issue && in_kind == pmsc_pkg::MEM_STRONG |-> any_cnt_r == CNT_ZERO)
    else $error("strongly-ordered overlaps another access");
  a_device_ordered: assert property (issue && in_kind == pmsc_pkg::MEM_DEVICE |-> ord_cnt_r == CNT_ZERO)
    else $error("device overlaps ordered access");
  a_strong_not_posted: assert property (accept && o_bus_kind == pmsc_pkg::MEM_STRONG |=> !o_wr_posted)
    else $error("strongly-ordered write posted");
  a_xn_fetch_faults: assert property (s_xn_fetch |=> s_fault_raised)
    else $error("execute-never fetch not faulted");
  a_byte_one_lane: assert property (issue && i_txn_size == pmsc_pkg::SIZE_BYTE |=> $onehot(o_bus_strb))
    else $error("byte access uses several lanes");

endmodule

// File: pmsc_pkg.sv
// Shared constants and types for the priority mask and stack control block
package pmsc_pkg;

  // ****************************************************************
  // Special register selection and layout
  // ****************************************************************
  localparam logic SREG_SEL_BASE_PRI = 1'b0;
  localparam logic SREG_SEL_CONTROL = 1'b1;
  localparam int BASE_PRI_LSB = 4;
  localparam int BASE_PRI_MSB = 7;
  localparam int BASE_PRI_W = 4;
  localparam logic [3:0] BASE_PRI_RST = 4'h0;
  localparam logic [3:0] BASE_PRI_OFF = 4'h0;
  localparam logic [3:0] PRIO_SUB_ZERO = 4'h0;
  localparam int CTRL_UNPRIV_BIT = 0;
  localparam int CTRL_STACK_POINTER_SELECT_BIT = 1;
  localparam int CTRL_FLOAT_CONTEXT_ACTIVE_BIT = 2;
  localparam logic CTRL_UNPRIV_RST = 1'b0;
  localparam logic CTRL_STACK_POINTER_SELECT_RST = 1'b0;
  localparam logic CTRL_FLOAT_CONTEXT_ACTIVE_RST = 1'b0;

  // ****************************************************************
  // Exception return code fields
  // ****************************************************************
  localparam int RET_CODE_W = 5;
  localparam int RET_PROC_STACK_BIT = 2;
  localparam int RET_TO_THREAD_BIT = 3;
  localparam int RET_NO_FLOAT_BIT = 4;

  // ****************************************************************
  // Access sizes and memory types
  // ****************************************************************
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  typedef enum logic [1:0] {MEM_NORMAL, MEM_DEVICE, MEM_STRONG} pmsc_mem_t;
  typedef enum logic {MODE_THREAD, MODE_HANDLER} pmsc_mode_t;

  // ****************************************************************
  // Fixed memory map, region start addresses
  // ****************************************************************
  localparam logic [31:0] MAP_SRAM_BASE = 32'h2000_0000;
  localparam logic [31:0] MAP_PERIPH_BASE = 32'h4000_0000;
  localparam logic [31:0] MAP_EXT_RAM_BASE = 32'h6000_0000;
  localparam logic [31:0] MAP_EXT_DEV_BASE = 32'hA000_0000;
  localparam logic [31:0] MAP_GAP_BASE = 32'hE000_0000;
  localparam logic [31:0] MAP_PRIV_BASE = 32'hED00_0000;
  localparam logic [31:0] MAP_MMAP_BASE = 32'hED10_0000;

endpackage

// File: pmsc_region_map.sv
// Fixed address map decode: memory type and execute-never per address
`timescale 1ns/10ps
module pmsc_region_map (
  // Address in
  input wire logic [31:0] i_addr,
  // Region attributes
  output pmsc_pkg::pmsc_mem_t o_mem_type,
  output logic o_execute_never
);

  // ****************************************************************
  // Decode
  // ****************************************************************
  // Unlisted hole below the private area is handled as Device, no execute
  always_comb begin
    if (i_addr < pmsc_pkg::MAP_SRAM_BASE) begin
      o_mem_type = pmsc_pkg::MEM_NORMAL;
      o_execute_never = 1'b0;
    end else if (i_addr < pmsc_pkg::MAP_PERIPH_BASE) begin
      o_mem_type = pmsc_pkg::MEM_NORMAL;
      o_execute_never = 1'b0;
    end else if (i_addr < pmsc_pkg::MAP_EXT_RAM_BASE) begin
      o_mem_type = pmsc_pkg::MEM_DEVICE;
      o_execute_never = 1'b1;
    end else if (i_addr < pmsc_pkg::MAP_EXT_DEV_BASE) begin
      o_mem_type = pmsc_pkg::MEM_NORMAL;
      o_execute_never = 1'b0;
    end else if (i_addr < pmsc_pkg::MAP_PRIV_BASE) begin
      o_mem_type = pmsc_pkg::MEM_DEVICE;
      o_execute_never = 1'b1;
    end else if (i_addr < pmsc_pkg::MAP_MMAP_BASE) begin
      o_mem_type = pmsc_pkg::MEM_STRONG;
      o_execute_never = 1'b1;
    end else begin
      o_mem_type = pmsc_pkg::MEM_DEVICE;
      o_execute_never = 1'b1;
    end
  end

endmodule

// File: priority_mask_stack_control_tb.sv
// Self-checking testbench for the priority mask and stack control block
`timescale 1ns/10ps
module priority_mask_stack_control_tb;
  // ****************************************************************
  // Signals and design instance
  // ****************************************************************
  logic i_ref_clk, i_rst_b, i_sreg_wr, i_sreg_rd, i_sreg_sel;
  logic [31:0] i_sreg_wdata, o_sreg_rdata;
  logic i_exc_entry, i_exception_return_code, o_exc_req_allow, o_handler_mode;
  logic o_stack_select, o_thread_unprivileged, o_save_float_state;
  logic [4:0] i_exception_return_code_code;
  logic [7:0] i_exc_req_prio;
  logic i_txn_valid, i_txn_fetch, i_txn_write, o_txn_ready, o_wr_posted, o_txn_complete, o_mm_fault;
  logic [1:0] i_txn_size;
  logic [31:0] i_txn_addr, i_txn_wdata, o_fault_addr, o_bus_addr, o_bus_wdata;
  logic o_bus_valid, o_bus_write, i_bus_ready, i_bus_done, i_bus_done_write;
  logic [3:0] o_bus_strb;
  pmsc_pkg::pmsc_mem_t o_bus_kind, i_bus_done_kind;
  int err_total = 0;
  int num_checks = 0;
  int last_wait;

  pmsc_core_ctrl #(.CNT_W(4)) pmsc_core_ctrl_inst (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_sreg_wr(i_sreg_wr), .i_sreg_rd(i_sreg_rd),
    .i_sreg_sel(i_sreg_sel), .i_sreg_wdata(i_sreg_wdata), .o_sreg_rdata(o_sreg_rdata),
    .i_exc_entry(i_exc_entry), .i_exception_return_code(i_exception_return_code), .i_exception_return_code_code(i_exception_return_code_code),
    .i_exc_req_prio(i_exc_req_prio), .o_exc_req_allow(o_exc_req_allow), .o_handler_mode(o_handler_mode),
    .o_stack_select(o_stack_select), .o_thread_unprivileged(o_thread_unprivileged),
    .o_save_float_state(o_save_float_state), .i_txn_valid(i_txn_valid), .i_txn_fetch(i_txn_fetch),
    .i_txn_write(i_txn_write), .i_txn_size(i_txn_size), .i_txn_addr(i_txn_addr), .i_txn_wdata(i_txn_wdata),
    .o_txn_ready(o_txn_ready), .o_wr_posted(o_wr_posted), .o_txn_complete(o_txn_complete),
    .o_mm_fault(o_mm_fault), .o_fault_addr(o_fault_addr), .o_bus_valid(o_bus_valid), .o_bus_addr(o_bus_addr),
    .o_bus_write(o_bus_write), .o_bus_strb(o_bus_strb), .o_bus_wdata(o_bus_wdata), .o_bus_kind(o_bus_kind),
    .i_bus_ready(i_bus_ready), .i_bus_done(i_bus_done), .i_bus_done_write(i_bus_done_write),
    .i_bus_done_kind(i_bus_done_kind)
  );

  initial i_ref_clk = 1'b0;
  always #10 i_ref_clk = ~i_ref_clk;

  // ****************************************************************
  // Checks and protocol tasks
  // ****************************************************************
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic sreg_wr(input logic sel, input logic [31:0] d);
    @(negedge i_ref_clk);
    i_sreg_wr = 1'b1;
    i_sreg_sel = sel;
    i_sreg_wdata = d;
    @(negedge i_ref_clk);
    i_sreg_wr = 1'b0;
  endtask

  task automatic sreg_rd(input logic sel, input logic [31:0] exp);
    @(negedge i_ref_clk);
    i_sreg_rd = 1'b1;
    i_sreg_sel = sel;
    @(negedge i_ref_clk);
    i_sreg_rd = 1'b0;
    chk(o_sreg_rdata, exp);
  endtask

  // Entry or return pulse, then the mode outputs are compared as {handler, stack, unpriv, float}
  task automatic exc(input logic ret, input logic [4:0] code, input logic [3:0] exp);
    @(negedge i_ref_clk);
    i_exc_entry = ~ret;
    i_exception_return_code = ret;
    i_exception_return_code_code = code;
    @(negedge i_ref_clk);
    i_exc_entry = 1'b0;
    i_exception_return_code = 1'b0;
    chk({28'h0, o_handler_mode, o_stack_select, o_thread_unprivileged, o_save_float_state}, {28'h0, exp});
  endtask

  task automatic prio_chk(input logic [7:0] p, input logic exp);
    @(negedge i_ref_clk);
    i_exc_req_prio = p;
    @(negedge i_ref_clk);
    chk({31'h0, o_exc_req_allow}, {31'h0, exp});
  endtask

  task automatic done(input logic w, input pmsc_pkg::pmsc_mem_t k);
    @(negedge i_ref_clk);
    i_bus_done = 1'b1;
    i_bus_done_write = w;
    i_bus_done_kind = k;
    @(negedge i_ref_clk);
    i_bus_done = 1'b0;
    chk({31'h0, o_txn_complete}, {31'h0, (!w || k == pmsc_pkg::MEM_STRONG)});
  endtask

  // Request held until taken; every non-Normal region of the fixed map is execute-never
  task automatic txn(input logic f, input logic w, input logic [1:0] sz, input logic [31:0] a,
                     input logic [31:0] d, input pmsc_pkg::pmsc_mem_t k, input logic [3:0] st,
                     input logic [31:0] wd, input logic fin);
    @(negedge i_ref_clk);
    {i_txn_valid, i_txn_fetch, i_txn_write, i_txn_size, i_txn_addr, i_txn_wdata} = {1'b1, f, w, sz, a, d};
    // Ready decodes the new address combinationally; read it once settled
    #1;
    last_wait = 0;
    while (o_txn_ready !== 1'b1) begin
      @(negedge i_ref_clk);
      last_wait++;
      if (last_wait > 50) begin
        err_total++;
        end_of_test();
      end
    end
    @(negedge i_ref_clk);
    i_txn_valid = 1'b0;
    if (f && k != pmsc_pkg::MEM_NORMAL) begin
      chk({30'h0, o_mm_fault, o_bus_valid}, 32'h2);
      chk(o_fault_addr, a);
    end else begin
      chk({o_mm_fault, o_bus_valid, o_bus_write, 27'h0, o_bus_kind}, {2'h1, w, 27'h0, k});
      chk(o_bus_addr, a);
      if (w) begin
        chk({28'h0, o_bus_strb}, {28'h0, st});
        chk(o_bus_wdata, wd);
      end
      i_bus_ready = 1'b1;
      @(negedge i_ref_clk);
      i_bus_ready = 1'b0;
      chk({o_bus_valid, o_wr_posted}, {1'b0, (w && k != pmsc_pkg::MEM_STRONG)});
      if (fin) begin
        done(w, k);
      end
    end
  endtask

  // Request offered for one cycle only; it must be held back
  task automatic probe(input logic [31:0] a);
    @(negedge i_ref_clk);
    {i_txn_valid, i_txn_fetch, i_txn_write, i_txn_size, i_txn_addr} = {3'b101, pmsc_pkg::SIZE_WORD, a};
    @(negedge i_ref_clk);
    chk({o_txn_ready, o_bus_valid}, 2'b00);
    i_txn_valid = 1'b0;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  localparam logic [31:0] MAP_ADDR [7] = '{32'h0000_0000, 32'h3FFF_FFFC, 32'h4000_0000, 32'h6000_0000,
                                           32'hA000_0000, 32'hED00_0000, 32'hED10_0000};
  localparam pmsc_pkg::pmsc_mem_t MAP_KIND [7] = '{pmsc_pkg::MEM_NORMAL, pmsc_pkg::MEM_NORMAL,
    pmsc_pkg::MEM_DEVICE, pmsc_pkg::MEM_NORMAL, pmsc_pkg::MEM_DEVICE, pmsc_pkg::MEM_STRONG, pmsc_pkg::MEM_DEVICE};

  initial begin
    {i_rst_b, i_sreg_wr, i_sreg_rd, i_sreg_sel, i_sreg_wdata} = '0;
    {i_exc_entry, i_exception_return_code, i_exception_return_code_code, i_exc_req_prio} = '0;
    {i_txn_valid, i_txn_fetch, i_txn_write, i_txn_size, i_txn_addr, i_txn_wdata} = '0;
    {i_bus_ready, i_bus_done, i_bus_done_write} = '0;
    i_bus_done_kind = pmsc_pkg::MEM_NORMAL;
    repeat (16) @(negedge i_ref_clk);
    i_rst_b = 1'b1;
    sreg_rd(pmsc_pkg::SREG_SEL_CONTROL, 32'h0);
    chk({o_handler_mode, o_stack_select}, 2'b00);
    sreg_wr(pmsc_pkg::SREG_SEL_BASE_PRI, 32'hFFFF_FF4F);
    sreg_rd(pmsc_pkg::SREG_SEL_BASE_PRI, 32'h0000_0040);
    prio_chk(8'h3F, 1'b1);
    prio_chk(8'h40, 1'b0);
    prio_chk(8'hFF, 1'b0);
    prio_chk(8'h00, 1'b1);
    sreg_wr(pmsc_pkg::SREG_SEL_BASE_PRI, 32'h0000_00F0);
    prio_chk(8'hEF, 1'b1);
    prio_chk(8'hF0, 1'b0);
    sreg_wr(pmsc_pkg::SREG_SEL_BASE_PRI, 32'h0000_000F);
    prio_chk(8'hFF, 1'b1);
    // Stack select is relied on only after a full cycle, standing in for the barrier
    sreg_wr(pmsc_pkg::SREG_SEL_CONTROL, 32'hFFFF_FFFF);
    chk({31'h0, o_stack_select}, 32'h1);
    sreg_rd(pmsc_pkg::SREG_SEL_CONTROL, 32'h0000_0007);
    exc(1'b0, 5'h00, 4'b1010);
    sreg_rd(pmsc_pkg::SREG_SEL_CONTROL, 32'h0000_0001);
    sreg_wr(pmsc_pkg::SREG_SEL_CONTROL, 32'hFFFF_FFFA);
    sreg_rd(pmsc_pkg::SREG_SEL_CONTROL, 32'h0000_0000);
    exc(1'b0, 5'h00, 4'b1000);
    exc(1'b1, 5'b01100, 4'b0101);
    sreg_rd(pmsc_pkg::SREG_SEL_CONTROL, 32'h0000_0006);
    exc(1'b1, 5'b11000, 4'b0101);
    exc(1'b0, 5'h00, 4'b1000);
    exc(1'b1, 5'b11000, 4'b0000);
    // Lane placement and replication of narrow writes
    txn(1'b0, 1'b1, pmsc_pkg::SIZE_BYTE, 32'h2000_0003, 32'hAB, pmsc_pkg::MEM_NORMAL, 4'h8, 32'hABAB_ABAB,
        1'b1);
    txn(1'b0, 1'b1, pmsc_pkg::SIZE_BYTE, 32'h2000_0001, 32'h5C, pmsc_pkg::MEM_NORMAL, 4'h2, 32'h5C5C_5C5C,
        1'b1);
    txn(1'b0, 1'b1, pmsc_pkg::SIZE_HALF, 32'h6000_0002, 32'h1234, pmsc_pkg::MEM_NORMAL, 4'hC, 32'h1234_1234,
        1'b1);
    txn(1'b0, 1'b1, pmsc_pkg::SIZE_HALF, 32'h6000_0000, 32'hBEEF, pmsc_pkg::MEM_NORMAL, 4'h3, 32'hBEEF_BEEF,
        1'b1);
    txn(1'b0, 1'b1, pmsc_pkg::SIZE_WORD, 32'h4000_0000, 32'h8765_4321, pmsc_pkg::MEM_DEVICE, 4'hF, 32'h8765_4321,
        1'b1);
    // Strongly-ordered write left open blocks everything behind it
    txn(1'b0, 1'b1, pmsc_pkg::SIZE_WORD, 32'hED00_0000, 32'h1, pmsc_pkg::MEM_STRONG, 4'hF, 32'h1, 1'b0);
    probe(32'h2000_0000);
    probe(32'h4000_0000);
    done(1'b1, pmsc_pkg::MEM_STRONG);
    // Posted Device write holds back Device and strong, not Normal
    txn(1'b0, 1'b1, pmsc_pkg::SIZE_WORD, 32'h4000_0010, 32'h2, pmsc_pkg::MEM_DEVICE, 4'hF, 32'h2, 1'b0);
    probe(32'hA000_0000);
    probe(32'hED00_0004);
    txn(1'b0, 1'b0, pmsc_pkg::SIZE_WORD, 32'h2000_0010, 32'h0, pmsc_pkg::MEM_NORMAL, 4'h0, 32'h0, 1'b1);
    chk(last_wait, 0);
    done(1'b1, pmsc_pkg::MEM_DEVICE);
    for (int i = 0; i < 7; i++) begin
      txn(1'b0, 1'b0, pmsc_pkg::SIZE_WORD, MAP_ADDR[i], 32'h0, MAP_KIND[i], 4'h0, 32'h0, 1'b1);
      txn(1'b1, 1'b0, pmsc_pkg::SIZE_WORD, MAP_ADDR[i], 32'h0, MAP_KIND[i], 4'h0, 32'h0, 1'b1);
    end
    txn(1'b1, 1'b0, pmsc_pkg::SIZE_WORD, 32'hE000_0000, 32'h0, pmsc_pkg::MEM_DEVICE, 4'h0, 32'h0, 1'b1);
    end_of_test();
  end
endmodule
